// ### inc/whrc_pkg.sv
// Purpose: Shared constants and types for the watchdog, halt and reset control block.
// Assumes: One 40 MHz clock; the watchdog oscillator tick arrives as a pin and is synchronised.
// Notes:   Register offsets are word indices; the byte address is four times the index.
package whrc_pkg;
   localparam int unsigned CLK_HZ             = 40000000;
   localparam int unsigned STARTUP_CYCLES     = 1024;
   localparam int unsigned OPTION_LOAD_CYCLES = 16;
   localparam int unsigned BASE_DIV_BITS      = 8;
   localparam int unsigned PRESCALE_BITS      = 7;
   localparam int unsigned WDOG_BITS          = BASE_DIV_BITS + PRESCALE_BITS;
   localparam int unsigned DELAY_BITS         = 11;

   localparam logic [3:0] IDX_PRESCALE_SELECT = 4'h9;
   localparam logic [3:0] IDX_STATUS          = 4'hA;
   localparam logic [3:0] IDX_CONFIG          = 4'hC;
   localparam logic [3:0] IDX_WAKE_ENABLE     = 4'hD;

   localparam logic [7:0] PRESCALE_RESET   = 8'h07;
   localparam logic [7:0] CONFIG_RESET     = 8'h03;
   localparam logic [7:0] WAKE_EN_RESET    = 8'h00;
   localparam int unsigned PS_LSB          = 0;
   localparam int unsigned PS_MSB          = 2;
   localparam int unsigned CFG_DOG_EN      = 0;
   localparam int unsigned CFG_DOG_OSC_SEL = 1;
   localparam int unsigned CFG_PAIRED      = 2;
   localparam int unsigned ST_PDF_BIT      = 4;
   localparam int unsigned ST_TO_BIT       = 5;

   typedef struct packed {
      logic clear_single;
      logic clear_first;
      logic clear_second;
      logic halt;
   } whrc_instr_s;

   typedef struct packed {
      logic pc_clear;
      logic sp_clear;
      logic full_reset;
      logic core_hold;
      logic osc_run;
   } whrc_core_ctl_s;

   typedef enum logic [3:0] {
      WHRC_OPTLOAD = 4'b0001,
      WHRC_STARTUP = 4'b0010,
      WHRC_RUN     = 4'b0100,
      WHRC_HALT    = 4'b1000
   } whrc_state_e;
endpackage

// ### design/whrc_sync.sv
// Purpose: Two-flop synchroniser per bit with falling-edge detect.
// Assumes: Inputs come from outside the clock domain.
// Notes:   The first flop feeds only the second.
module whrc_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clock,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out,
   output logic      [WIDTH-1:0] fall_pulse
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clock) begin
            if (sys_rst) begin
               stage1[i] <= 1'b1;
               stage2[i] <= 1'b1;
               stage3[i] <= 1'b1;
            end else begin
               stage1[i] <= async_in[i];
               stage2[i] <= stage1[i];
               stage3[i] <= stage2[i];
            end
         end
         assign fall_pulse[i] = stage3[i] & ~stage2[i];
      end
   endgenerate
   assign sync_out = stage2;
endmodule

// ### design/whrc_dog.sv
// Purpose: Watchdog divider chain: fixed divide by 256, then power-of-two prescale.
// Assumes: tick is a one-cycle enable at the chosen watchdog rate.
// Notes:   Overflow is a one-cycle pulse when the selected stage wraps.
module whrc_dog
   import whrc_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire logic       tick,
   input  wire logic       clear,
   input  wire logic [2:0] ratio,
   output logic            overflow
);
   logic [WDOG_BITS-1:0] count;
   logic [WDOG_BITS-1:0] next_count;
   logic [WDOG_BITS:0]   limit;
   logic                 at_top;

   // Timeout spans 256 times 2^ratio ticks
   assign limit      = (WDOG_BITS+1)'(1) << (BASE_DIV_BITS + 32'(ratio));
   // At or past the top: lowering the ratio mid-count must still expire promptly
   assign at_top     = ({1'b0, count} >= (limit - (WDOG_BITS+1)'(1)));
   assign next_count = at_top ? '0 : count + WDOG_BITS'(1);

   always_ff @(posedge clock) begin
      if (sys_rst || clear) begin
         count <= '0;
      end else if (tick) begin
         count <= next_count;
      end
   end
   assign overflow = tick & at_top & ~clear;
endmodule

// ### design/whrc_top.sv
// Purpose: Watchdog, halt and reset sequencing with an Avalon-MM register slave.
// Assumes: sys_rst is power-on reset; core drives instruction pulses and interrupt state.
// Notes:   Registers answer with one wait state; unmapped reads return zero.
//
// Design decision made here: the Avalon-MM slave port.
module whrc_top
   import whrc_pkg::*;
(
   input  wire logic                 clock,
   input  wire logic                 sys_rst,
   input  wire logic [5:0]           avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   input  wire logic [3:0]           avs_byteenable,
   output logic      [31:0]          avs_readdata,
   output logic                      avs_waitrequest,
   input  wire logic                 external_reset_pin_n,
   input  wire logic [7:0]           port_a_pins,
   input  wire logic                 dog_osc_pin,
   input  wire logic                 instr_tick,
   input  wire whrc_pkg::whrc_instr_s instr,
   input  wire logic                 irq_request,
   input  wire logic                 irq_enabled,
   input  wire logic                 stack_full,
   output whrc_pkg::whrc_core_ctl_s  core_ctl,
   output logic                      take_interrupt,
   output logic                      expiry_flag,
   output logic                      powerdown_flag
);
   whrc_state_e state;
   whrc_state_e next_state;
   logic [DELAY_BITS-1:0] delay_cnt;
   logic [7:0]  watchdog_select_register;
   logic [7:0]  config_reg;
   logic [7:0]  wake_enable;
   logic        pair_first_seen;
   logic        pair_second_seen;
   logic        irq_wake_blocked;
   logic        irq_wake_pending;
   logic        ack_pending;
   logic        wait_done;
   logic [31:0] rd_mux;

   // Pin synchronisation; reset pin and watchdog oscillator share one instance
   logic [9:0] pin_sync;
   logic [9:0] pin_fall;
   whrc_sync #(.WIDTH(10)) u_sync (
      .clock      (clock),
      .sys_rst    (sys_rst),
      .async_in   ({dog_osc_pin, external_reset_pin_n, port_a_pins}),
      .sync_out   (pin_sync),
      .fall_pulse (pin_fall)
   );
   wire       reset_pin_low = ~pin_sync[8];
   wire       dog_osc_tick  = pin_fall[9];
   wire [7:0] port_a_fall   = pin_fall[7:0];

   // Option bits
   wire dog_enabled = config_reg[CFG_DOG_EN];
   wire dog_own_osc = config_reg[CFG_DOG_OSC_SEL];
   wire paired_mode = config_reg[CFG_PAIRED];
   wire halted      = (state == WHRC_HALT);
   wire running     = (state == WHRC_RUN);

   // Clear strobes act only while running with the watchdog enabled; halt acts whenever running
   wire instr_ok     = running & dog_enabled;
   wire do_halt      = running & instr.halt;
   wire do_single    = instr_ok & ~paired_mode & instr.clear_single;
   wire got_first    = instr_ok & paired_mode & instr.clear_first;
   wire got_second   = instr_ok & paired_mode & instr.clear_second;
   wire pair_done    = (pair_first_seen | got_first) & (pair_second_seen | got_second);
   wire do_pair      = instr_ok & paired_mode & pair_done;

   // Instruction clock stops in halt; own oscillator keeps running
   wire dog_tick     = dog_enabled & (dog_own_osc ? dog_osc_tick : (instr_tick & running));
   wire dog_clear    = reset_pin_low | do_single | do_pair | do_halt | ~dog_enabled;
   logic dog_overflow;
   whrc_dog u_dog (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .tick     (dog_tick),
      .clear    (dog_clear),
      .ratio    (watchdog_select_register[PS_MSB:PS_LSB]),
      .overflow (dog_overflow)
   );

   wire dog_full_reset = dog_overflow & running;
   wire dog_warm_reset = dog_overflow & halted;
   wire port_wake      = halted & |(port_a_fall & wake_enable);
   wire irq_wake       = halted & irq_request & ~irq_wake_blocked;
   wire pin_reset      = reset_pin_low & ~halted;
   wire pin_wake       = reset_pin_low & halted;
   wire any_wake       = port_wake | irq_wake | dog_warm_reset | pin_wake;
   wire sys_reset      = pin_reset | pin_wake | dog_full_reset;

   assign wait_done = (delay_cnt == DELAY_BITS'(0));

   always_comb begin
      next_state = state;
      unique case (state)
         WHRC_OPTLOAD: if (wait_done && !reset_pin_low) next_state = WHRC_STARTUP;
         WHRC_STARTUP: if (wait_done) next_state = WHRC_RUN;
         WHRC_RUN:     if (do_halt) next_state = WHRC_HALT;
         WHRC_HALT:    if (any_wake) next_state = WHRC_STARTUP;
      endcase
      if (sys_reset) next_state = WHRC_OPTLOAD;
      if (dog_warm_reset) next_state = WHRC_STARTUP;
   end

   wire enter_startup = (next_state == WHRC_STARTUP) && (state != WHRC_STARTUP);

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state <= WHRC_OPTLOAD;
         delay_cnt <= DELAY_BITS'(OPTION_LOAD_CYCLES - 1);
      end else begin
         state <= next_state;
         if (next_state == WHRC_OPTLOAD && state != WHRC_OPTLOAD) begin
            delay_cnt <= DELAY_BITS'(OPTION_LOAD_CYCLES - 1);
         end else if (enter_startup) begin
            delay_cnt <= DELAY_BITS'(STARTUP_CYCLES - 1);
         end else if (!wait_done) begin
            delay_cnt <= delay_cnt - DELAY_BITS'(1);
         end
      end
   end

   // Paired clear bookkeeping
   always_ff @(posedge clock) begin
      if (sys_rst || do_pair || !paired_mode || sys_reset) begin
         pair_first_seen  <= 1'b0;
         pair_second_seen <= 1'b0;
      end else begin
         if (got_first)  pair_first_seen  <= 1'b1;
         if (got_second) pair_second_seen <= 1'b1;
      end
   end

   // Cause flags; a clear in the same cycle suppresses the timeout
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         expiry_flag    <= 1'b0;
         powerdown_flag <= 1'b0;
      end else begin
         if (dog_overflow) begin
            expiry_flag <= 1'b1;
         end else if (do_halt || do_single) begin
            expiry_flag <= 1'b0;
         end
         if (do_halt) begin
            powerdown_flag <= 1'b1;
         end else if (do_single) begin
            powerdown_flag <= 1'b0;
         end
      end
   end

   // Interrupt wake handling
   always_ff @(posedge clock) begin
      if (sys_rst || sys_reset) begin
         irq_wake_blocked <= 1'b0;
         irq_wake_pending <= 1'b0;
         ack_pending      <= 1'b0;
      end else begin
         if (do_halt) irq_wake_blocked <= irq_request;
         if (irq_wake) irq_wake_pending <= 1'b1;
         else if (any_wake) irq_wake_pending <= 1'b0;
         ack_pending <= (state == WHRC_STARTUP) && wait_done && irq_wake_pending
                        && irq_enabled && !stack_full;
      end
   end
   assign take_interrupt = ack_pending;

   // Core control; hold and reset lines are registered from the next_state decode and warm reset
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         core_ctl <= '{pc_clear: 1'b1, sp_clear: 1'b1, full_reset: 1'b1,
                       core_hold: 1'b1, osc_run: 1'b1};
      end else begin
         core_ctl.full_reset <= (next_state == WHRC_OPTLOAD);
         core_ctl.pc_clear   <= (next_state == WHRC_OPTLOAD) || dog_warm_reset;
         core_ctl.sp_clear   <= (next_state == WHRC_OPTLOAD) || dog_warm_reset;
         core_ctl.core_hold  <= (next_state != WHRC_RUN);
         core_ctl.osc_run    <= (next_state != WHRC_HALT);
      end
   end

   // Register slave
   logic rd_pending;
   wire  wr_sel   = avs_write & ~avs_waitrequest;
   wire  be0      = avs_byteenable[0];
   wire  hit_ps   = (avs_address[3:0] == IDX_PRESCALE_SELECT) && (avs_address[5:4] == 2'h0);
   wire  hit_st   = (avs_address[3:0] == IDX_STATUS) && (avs_address[5:4] == 2'h0);
   wire  hit_cfg  = (avs_address[3:0] == IDX_CONFIG) && (avs_address[5:4] == 2'h0);
   wire  hit_wen  = (avs_address[3:0] == IDX_WAKE_ENABLE) && (avs_address[5:4] == 2'h0);
   wire [7:0] status_byte = (8'(expiry_flag) << ST_TO_BIT) | (8'(powerdown_flag) << ST_PDF_BIT);
   assign rd_mux = hit_ps  ? {24'h000000, watchdog_select_register} :
                   hit_st  ? {24'h000000, status_byte} :
                   hit_cfg ? {24'h000000, config_reg} :
                   hit_wen ? {24'h000000, wake_enable} : 32'h00000000;
   assign avs_waitrequest = (avs_read | avs_write) & ~rd_pending;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rd_pending   <= 1'b0;
         avs_readdata <= 32'h00000000;
      end else begin
         rd_pending   <= (avs_read | avs_write) & ~rd_pending;
         if (avs_read && !rd_pending) avs_readdata <= rd_mux;
      end
   end

   // Warm reset leaves these untouched; full reset restores only the prescale select
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         watchdog_select_register <= PRESCALE_RESET;
         config_reg               <= CONFIG_RESET;
         wake_enable              <= WAKE_EN_RESET;
      end else if (sys_reset) begin
         watchdog_select_register <= PRESCALE_RESET;
      end else if (wr_sel && be0) begin
         if (hit_ps)  watchdog_select_register <= avs_writedata[7:0];
         if (hit_cfg) config_reg               <= avs_writedata[7:0];
         if (hit_wen) wake_enable              <= avs_writedata[7:0];
      end
   end
endmodule

// ### tb/whrc_top_chk.sv
// Purpose: Port-level assertions for whrc_top.
// Assumes: One clock; sys_rst synchronous, active high.
// Notes:   Bound to every whrc_top instance.
module whrc_top_chk
   import whrc_pkg::*;
(
   input wire logic                     clock,
   input wire logic                     sys_rst,
   input wire logic                     avs_read,
   input wire logic                     avs_write,
   input wire logic [31:0]              avs_readdata,
   input wire logic                     avs_waitrequest,
   input wire whrc_pkg::whrc_instr_s    instr,
   input wire logic                     irq_enabled,
   input wire logic                     stack_full,
   input wire whrc_pkg::whrc_core_ctl_s core_ctl,
   input wire logic                     take_interrupt,
   input wire logic                     expiry_flag,
   input wire logic                     powerdown_flag
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int MIN_HOLD = 1020;
   logic [11:0] hold_cnt;
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Saturates so a long halt cannot wrap into a short count
   always_ff @(posedge clock) begin
      if (sys_rst || !core_ctl.core_hold) hold_cnt <= 12'h0;
      else if (hold_cnt != 12'hFFF) hold_cnt <= hold_cnt + 12'h1;
   end
   AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("bus answer late");
   AST_RD_HIGH: assert property (avs_read && !avs_waitrequest
      |-> avs_readdata[31:8] == 24'h0) else $error("read data high bits set");
   AST_RST_CTL: assert property (disable iff (1'b0) sys_rst |=> core_ctl == 5'h1F
      && !expiry_flag && !powerdown_flag) else $error("reset state wrong");
   AST_HALT_FLAGS: assert property (instr.halt && !core_ctl.core_hold
      |=> powerdown_flag && !expiry_flag) else $error("halt flags wrong");
   AST_HALT_OSC: assert property (instr.halt && !core_ctl.core_hold
      |=> !core_ctl.osc_run [*2]) else $error("oscillator runs in halt");
   AST_FULL_INIT: assert property (core_ctl.full_reset
      |-> core_ctl.pc_clear && core_ctl.sp_clear && core_ctl.core_hold)
      else $error("full reset incomplete");
   AST_IRQ_OK: assert property (take_interrupt |-> irq_enabled && !stack_full)
      else $error("interrupt taken while blocked");
   AST_IRQ_ONE: assert property (take_interrupt |=> !take_interrupt)
      else $error("interrupt pulse too long");
   AST_WARM_FLAGS: assert property (core_ctl.pc_clear && !core_ctl.full_reset
      |-> ##[0:2] expiry_flag) else $error("warm reset without expiry");
   AST_HOLD_LEN: assert property ($fell(core_ctl.core_hold)
      |-> hold_cnt >= MIN_HOLD) else $error("start-up delay short");
   cover property (take_interrupt);
   cover property (core_ctl.pc_clear && !core_ctl.full_reset);
   cover property ($fell(core_ctl.core_hold));
endmodule

bind whrc_top whrc_top_chk u_chk (.clock(clock), .sys_rst(sys_rst), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .instr(instr), .irq_enabled(irq_enabled), .stack_full(stack_full), .core_ctl(core_ctl),
   .take_interrupt(take_interrupt), .expiry_flag(expiry_flag),
   .powerdown_flag(powerdown_flag));

// ### tb/whrc_core_model.sv
// Purpose: Core, reset pin and port A model facing whrc_top.
// Assumes: Bench sets the levels here by hierarchical assignment.
// Notes:   Instruction strobes wait until the core is released.
module whrc_core_model
   import whrc_pkg::*;
(
   input  wire logic                     clock,
   input  wire whrc_pkg::whrc_core_ctl_s core_ctl,
   output whrc_pkg::whrc_instr_s         instr,
   output logic                          instr_tick,
   output logic                          irq_request,
   output logic                          irq_enabled,
   output logic                          stack_full,
   output logic [7:0]                    port_a_pins,
   output logic                          external_reset_pin_n,
   output logic                          dog_osc_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       tick_on;
   logic [1:0] osc_div;
   initial begin
      instr = '0;
      tick_on = 1'b0;
      irq_request = 1'b0;
      irq_enabled = 1'b1;
      stack_full = 1'b0;
      port_a_pins = 8'hFF;
      external_reset_pin_n = 1'b1;
      osc_div = 2'h0;
   end
   // Free-running watchdog oscillator at a quarter of the system rate
   always @(posedge clock) begin
      osc_div <= osc_div + 2'h1;
   end
   assign dog_osc_pin = osc_div[1];
   assign instr_tick  = tick_on;
   task automatic issue(input whrc_instr_s kind);
      int n;
      n = 0;
      while (core_ctl.core_hold !== 1'b0 && n < 3000) begin
         @(posedge clock);
         n++;
      end
      instr <= kind;
      @(posedge clock);
      instr <= '0;
      @(posedge clock);
   endtask
endmodule

// ### tb/whrc_top_tb.sv
// Purpose: Self-checking bench for whrc_top over Avalon-MM.
// Assumes: 40 MHz clock; partner model drives the core side.
// Notes:   Watchdog runs at ratio 0 for short time-outs.
module whrc_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import whrc_pkg::*;
   logic clock, sys_rst, avs_read, avs_write, avs_waitrequest, take_interrupt;
   logic expiry_flag, powerdown_flag, instr_tick, irq_request, irq_enabled;
   logic stack_full, external_reset_pin_n, dog_osc_pin;
   logic [5:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0]  avs_byteenable;
   logic [7:0]  port_a_pins;
   whrc_instr_s    instr;
   whrc_core_ctl_s core_ctl;
   int n_errors, checks, n, k, kf, cnt_full, cnt_warm, cnt_irq;
   whrc_top dut (.clock(clock), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .external_reset_pin_n(external_reset_pin_n),
      .port_a_pins(port_a_pins), .dog_osc_pin(dog_osc_pin), .instr_tick(instr_tick),
      .instr(instr), .irq_request(irq_request), .irq_enabled(irq_enabled),
      .stack_full(stack_full), .core_ctl(core_ctl), .take_interrupt(take_interrupt),
      .expiry_flag(expiry_flag), .powerdown_flag(powerdown_flag));
   whrc_core_model core (.clock(clock), .core_ctl(core_ctl), .instr(instr),
      .instr_tick(instr_tick), .irq_request(irq_request), .irq_enabled(irq_enabled),
      .stack_full(stack_full), .port_a_pins(port_a_pins), .dog_osc_pin(dog_osc_pin),
      .external_reset_pin_n(external_reset_pin_n));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock) begin
      cnt_full += int'(core_ctl.full_reset === 1'b1);
      cnt_warm += int'(core_ctl.pc_clear === 1'b1 && core_ctl.sp_clear === 1'b1
                       && core_ctl.full_reset === 1'b0);
      cnt_irq  += int'(take_interrupt === 1'b1);
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d,
                      input logic [3:0] be);
      int w;
      w = 0;
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      do begin
         @(posedge clock);
         w++;
      end while (avs_waitrequest !== 1'b0 && w < 50);
      q = avs_readdata;
      chk("bus answer", 32'h1, 32'(w < 50));
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h0, 4'hF);
      chk("register", {24'h0, exp}, q);
   endtask
   task automatic hold_low();
      n = 0;
      while (core_ctl.core_hold !== 1'b0 && n < 5000) begin
         @(posedge clock);
         n++;
      end
   endtask
   task automatic flags(input logic [1:0] exp);
      chk("expiry and powerdown", {30'h0, exp}, {30'h0, expiry_flag, powerdown_flag});
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clock);
      n_errors++;
      give_verdict();
   end
   initial begin
      {sys_rst, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 40'h0};
      {avs_byteenable, n_errors, checks, cnt_full, cnt_warm, cnt_irq} = '0;
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      hold_low();
      chk("start-up length", 32'h1, 32'(n >= 1040 && n <= 1046));
      flags(2'b00);
      rd(6'h09, 8'h07);
      rd(6'h0A, 8'h00);
      rd(6'h0C, 8'h03);
      rd(6'h0D, 8'h00);
      rd(6'h01, 8'h00);
      bus(1'b1, 6'h09, 8'h55, 4'hE);
      rd(6'h09, 8'h07);
      bus(1'b1, 6'h0A, 8'hFF, 4'hF);
      rd(6'h0A, 8'h00);
      bus(1'b1, 6'h09, 8'hF7, 4'hF);
      rd(6'h09, 8'hF7);
      bus(1'b1, 6'h0D, 8'h01, 4'hF);
      $display("test registers done");
      core.issue(4'h1);
      flags(2'b01);
      chk("oscillator", 32'h0, 32'(core_ctl.osc_run));
      rd(6'h0A, 8'h10);
      core.port_a_pins <= 8'hFD;
      repeat (40) @(posedge clock);
      chk("oscillator", 32'h0, 32'(core_ctl.osc_run));
      core.port_a_pins <= 8'hFC;
      hold_low();
      chk("wake length", 32'h1, 32'(n >= 1024 && n <= 1034));
      chk("full reset", 32'h0, 32'(core_ctl.full_reset));
      core.port_a_pins <= 8'hFF;
      core.issue(4'h8);
      flags(2'b00);
      $display("test port wake done");
      for (int sf = 0; sf < 3; sf++) begin
         core.stack_full <= (sf == 1);
         core.irq_enabled <= (sf != 2);
         core.issue(4'h1);
         repeat (20) @(posedge clock);
         k = cnt_irq;
         core.irq_request <= 1'b1;
         hold_low();
         repeat (4) @(posedge clock);
         chk("interrupts taken", 32'(sf == 0), 32'(cnt_irq - k));
         core.irq_request <= 1'b0;
      end
      @(posedge clock);
      core.irq_enabled <= 1'b1;
      core.irq_request <= 1'b1;
      core.issue(4'h1);
      repeat (200) @(posedge clock);
      chk("oscillator", 32'h0, 32'(core_ctl.osc_run));
      core.port_a_pins <= 8'hFE;
      hold_low();
      {core.port_a_pins, core.irq_request} <= {8'hFF, 1'b0};
      $display("test interrupt wake done");
      bus(1'b1, 6'h0C, 8'h01, 4'hF);
      bus(1'b1, 6'h09, 8'h00, 4'hF);
      k = cnt_full;
      core.tick_on <= 1'b1;
      repeat (300) @(posedge clock);
      chk("full resets", 32'h1, 32'(cnt_full > k));
      flags(2'b11);
      core.tick_on <= 1'b0;
      hold_low();
      rd(6'h09, 8'h07);
      core.issue(4'h8);
      bus(1'b1, 6'h0C, 8'h05, 4'hF);
      bus(1'b1, 6'h09, 8'h00, 4'hF);
      k = cnt_full;
      core.tick_on <= 1'b1;
      repeat (4) begin
         repeat (150) @(posedge clock);
         core.issue(4'h4);
         core.issue(4'h2);
      end
      chk("full resets", k, cnt_full);
      repeat (3) begin
         repeat (150) @(posedge clock);
         core.issue(4'h4);
      end
      chk("full resets", 32'h1, 32'(cnt_full > k));
      core.tick_on <= 1'b0;
      hold_low();
      $display("test watchdog run done");
      bus(1'b1, 6'h0C, 8'h03, 4'hF);
      bus(1'b1, 6'h09, 8'h00, 4'hF);
      core.issue(4'h1);
      {k, kf, n} = {cnt_warm, cnt_full, 32'h0};
      while (cnt_warm == k && n < 2000) begin
         @(posedge clock);
         n++;
      end
      chk("warm resets", 32'h1, 32'(cnt_warm > k));
      chk("full resets", kf, cnt_full);
      hold_low();
      flags(2'b11);
      rd(6'h09, 8'h00);
      bus(1'b1, 6'h09, 8'h07, 4'hF);
      $display("test warm reset done");
      k = cnt_full;
      core.external_reset_pin_n <= 1'b0;
      repeat (10) @(posedge clock);
      core.external_reset_pin_n <= 1'b1;
      hold_low();
      chk("full resets", 32'h1, 32'(cnt_full > k));
      flags(2'b11);
      bus(1'b1, 6'h0C, 8'h00, 4'hF);
      core.issue(4'h8);
      flags(2'b11);
      $display("test reset pin done");
      give_verdict();
   end
endmodule
